//--- src/led_dot_matrix_scan_driver.v
// What this block does
// - Scan only when mode 10, enabled, LED selected
// - Drive 56 dots on eight lines
// - Dot n at byte n/8, bit n%8
// - Memory bit one lights, zero keeps dark
// - Dot address independent of matrix size
// - Size field picks matrix and line range
// - Segment-common mode: field picks duty, commons
// - Mode 00 segment-common, 10 dot; others none
// - Eight brightness levels, reset brightest
// - Brightness mode: uniform or enhanced, reset uniform
// - Scan clock prescaler divides 64/32/16/8
// - Lines 0-3 on port0 pins, gated
// - Lines 4-5 on port2 pins 0-1, gated
// - Line 7 on port3.4, line 6 port3.7
// - Pin enable hands pin to driver
// - Only one drive mode at a time
`include "led_dmx_regs.vh"

module led_dot_matrix_scan_driver #(
  parameter LINES = 8,
  parameter MEM_DEPTH = 8,
  parameter MEM_AW = 3
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [7:0] sfr_addr_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [7:0] sfr_wdata_i,
  output wire [7:0] sfr_rdata_o,
  input wire [15:0] dmem_addr_i,
  input wire dmem_wr_i,
  input wire [7:0] dmem_wdata_i,
  output wire [LINES-1:0] drive_line_o,
  output wire [LINES-1:0] drive_line_oe_n_o,
  output wire [7:0] port0_display_sel_o,
  output wire [7:0] port1_display_sel_o,
  output wire [1:0] port2_display_sel_o,
  output wire [7:0] port3_display_sel_o,
  output wire dot_matrix_scan_o,
  output wire segment_common_scan_o,
  output wire [3:0] segment_common_count_o
);

  localparam ST_IDLE = 3'h0;
  localparam ST_RD_LO = 3'h1;
  localparam ST_RD_HI = 3'h2;
  localparam ST_LOAD = 3'h3;
  localparam ST_SHOW = 3'h4;

  // Matrix size code to {rows, commons}; reserved codes give zero
  function [7:0] size_dims;
    input [2:0] code;
    begin
      case (code)
        3'h0: size_dims = {4'h4, 4'h4};
        3'h1: size_dims = {4'h5, 4'h5};
        3'h2: size_dims = {4'h6, 4'h6};
        3'h3: size_dims = {4'h6, 4'h7};
        3'h4: size_dims = {4'h7, 4'h7};
        3'h5: size_dims = {4'h7, 4'h8};
        default: size_dims = 8'h00;
      endcase
    end
  endfunction

  // Last prescaler count for the selected divide ratio
  function [5:0] psc_last;
    input [1:0] sel;
    reg [6:0] div;
    begin
      div = `PSC_MAX_DIV >> sel;
      psc_last = div[5:0] - 6'h01;
    end
  endfunction

  reg [7:0] port0_en_q;
  reg [7:0] port1_en_q;
  reg [1:0] port2_en_q;
  reg [7:0] port3_en_q;
  reg display_enable_q;
  reg [2:0] size_q;
  reg brightness_mode_q;
  reg [2:0] brightness_level_q;
  reg [1:0] prescaler_q;
  reg lcd_or_led_q;
  reg [1:0] scan_mode_q;
  reg [7:0] sfr_rdata_q;

  reg [2:0] state_q;
  reg [2:0] com_q;
  reg [2:0] sub_q;
  reg [5:0] psc_q;
  reg [7:0] lo_byte_q;
  reg [6:0] row_bits_q;
  reg [LINES-1:0] line_q;
  reg [LINES-1:0] line_oe_n_q;

  wire [7:0] dims = size_dims(size_q);
  wire [3:0] rows = dims[7:4];
  wire [3:0] cols = dims[3:0];
  wire led_on = display_enable_q & lcd_or_led_q;
  wire dot_scan_on = led_on && (scan_mode_q == `MODE_DOT_MATRIX) && (cols != 4'h0);
  wire seg_scan_on = led_on && (scan_mode_q == `MODE_SEG_COMMON);
  wire tick = (psc_q == psc_last(prescaler_q));

  // first dot of a common is com*7, fixed for every size
  wire [5:0] first_dot = {3'h0, com_q} * 6'h07;
  wire [2:0] byte_lo = first_dot[5:3];
  wire [2:0] bit_off = first_dot[2:0];
  wire [7:0] mem_rd_data;
  wire [15:0] pair = {mem_rd_data, lo_byte_q} >> bit_off;

  wire mem_rd_en = (state_q == ST_RD_LO) || (state_q == ST_RD_HI);
  wire [2:0] mem_rd_addr = (state_q == ST_RD_HI) ? byte_lo + 3'h1 : byte_lo;
  wire [15:0] dmem_off = dmem_addr_i - `DMEM_BASE;
  wire dmem_hit = dmem_wr_i && (dmem_addr_i >= `DMEM_BASE) && (dmem_addr_i <= `DMEM_LAST);

  display_memory #(
    .WIDTH(8),
    .DEPTH(MEM_DEPTH),
    .AW(MEM_AW)
  ) u_mem (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wr_en_i(dmem_hit),
    .wr_addr_i(dmem_off[MEM_AW-1:0]),
    .wr_data_i(dmem_wdata_i),
    .rd_en_i(mem_rd_en),
    .rd_addr_i(mem_rd_addr[MEM_AW-1:0]),
    .rd_data_o(mem_rd_data)
  );

  // Register writes
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      port0_en_q <= `RST_PIN_EN;
      port1_en_q <= `RST_PIN_EN;
      port2_en_q <= `RST_PORT2_PIN_EN;
      port3_en_q <= `RST_PIN_EN;
      display_enable_q <= `RST_ENABLE;
      size_q <= `RST_SIZE;
      brightness_mode_q <= `RST_BRIGHT_MODE;
      brightness_level_q <= `RST_BRIGHTNESS;
      prescaler_q <= `RST_PRESCALER;
      lcd_or_led_q <= `RST_LCD_LED;
      scan_mode_q <= `RST_SCAN_MODE;
    end else if (ce_i && sfr_wr_i) begin
      case (sfr_addr_i)
        `REG_PORT0_PIN_EN: port0_en_q <= sfr_wdata_i;
        `REG_PORT1_PIN_EN: port1_en_q <= sfr_wdata_i;
        `REG_PORT2_PIN_EN: port2_en_q <= sfr_wdata_i[1:0];
        `REG_PORT3_PIN_EN: port3_en_q <= sfr_wdata_i;
        `REG_DISP_CTRL: begin
          display_enable_q <= sfr_wdata_i[`POS_DISPLAY_ENABLE];
          size_q <= sfr_wdata_i[`POS_SIZE_LO+2:`POS_SIZE_LO];
          brightness_mode_q <= sfr_wdata_i[`POS_BRIGHT_MODE];
          brightness_level_q <= sfr_wdata_i[`POS_BRIGHT_LO+2:`POS_BRIGHT_LO];
        end
        `REG_DISP_CTRL2: begin
          prescaler_q <= sfr_wdata_i[`POS_PRESCALER_LO+1:`POS_PRESCALER_LO];
          lcd_or_led_q <= sfr_wdata_i[`POS_LCD_LED];
          scan_mode_q <= sfr_wdata_i[`POS_SCAN_MODE_LO+1:`POS_SCAN_MODE_LO];
        end
        default: begin
        end
      endcase
    end
  end

  // Read data appears the cycle after sfr_rd_i; reserved and unmapped bits read zero
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      sfr_rdata_q <= 8'h00;
    end else if (ce_i && sfr_rd_i) begin
      case (sfr_addr_i)
        `REG_PORT0_PIN_EN: sfr_rdata_q <= port0_en_q;
        `REG_PORT1_PIN_EN: sfr_rdata_q <= port1_en_q;
        `REG_PORT2_PIN_EN: sfr_rdata_q <= {6'h00, port2_en_q};
        `REG_PORT3_PIN_EN: sfr_rdata_q <= port3_en_q;
        `REG_DISP_CTRL: sfr_rdata_q <= {display_enable_q, size_q, brightness_mode_q, brightness_level_q};
        `REG_DISP_CTRL2: sfr_rdata_q <= {1'b0, prescaler_q, lcd_or_led_q, 2'h0, scan_mode_q};
        default: sfr_rdata_q <= 8'h00;
      endcase
    end
  end

  // Scan sequencer: fetch two bytes per common, then show for eight LED clock ticks
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      com_q <= 3'h0;
      sub_q <= 3'h0;
      psc_q <= 6'h00;
      lo_byte_q <= 8'h00;
      row_bits_q <= 7'h00;
    end else if (ce_i) begin
      if (!dot_scan_on) begin
        state_q <= ST_IDLE;
        com_q <= 3'h0;
        sub_q <= 3'h0;
        psc_q <= 6'h00;
      end else begin
        psc_q <= tick ? 6'h00 : psc_q + 6'h01;
        case (state_q)
          ST_IDLE: state_q <= ST_RD_LO;
          ST_RD_LO: state_q <= ST_RD_HI;
          ST_RD_HI: begin
            lo_byte_q <= mem_rd_data;
            state_q <= ST_LOAD;
          end
          ST_LOAD: begin
            row_bits_q <= pair[6:0];
            sub_q <= 3'h0;
            psc_q <= 6'h00;
            state_q <= ST_SHOW;
          end
          ST_SHOW: begin
            if (tick) begin
              if (sub_q == `SLOT_TICKS) begin
                // next common, wrapping at the selected size
                com_q <= ({1'b0, com_q} >= cols - 4'h1) ? 3'h0 : com_q + 3'h1;
                state_q <= ST_RD_LO;
              end else begin
                sub_q <= sub_q + 3'h1;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // uniform mode blanks the first tick of each slot to curb ghosting
  // enhanced mode drops that blank for one more tick of light
  wire bright_window = brightness_mode_q ? (sub_q <= brightness_level_q) :
                       ((sub_q != 3'h0) && (sub_q <= brightness_level_q));
  wire showing = (state_q == ST_SHOW);

  wire [LINES-1:0] line_pin_en = {port3_en_q[4], port3_en_q[7], port2_en_q, port0_en_q[3:0]};

  wire [LINES-1:0] line_d;
  wire [LINES-1:0] line_oe_n_d;

  genvar k;
  generate
    for (k = 0; k < LINES; k = k + 1) begin : g_line
      localparam integer KI = k;
      wire [2:0] line_idx = KI[2:0];
      wire [2:0] row_idx = (line_idx < com_q) ? line_idx : line_idx - 3'h1;
      // lit only for set bits within the selected rows
      wire lit = row_bits_q[row_idx] && ({1'b0, row_idx} < rows) && (line_idx != com_q);
      // One process per line keeps each bit with a single driver
      reg line_bit;
      reg oe_n_bit;
      always @* begin
        line_bit = 1'b0;
        oe_n_bit = 1'b1;
        // only pins handed to the driver are driven
        if (showing && line_pin_en[k]) begin
          if (line_idx == com_q) begin
            // common sinks for the whole slot
            oe_n_bit = 1'b0;
          end else if (lit && bright_window) begin
            line_bit = 1'b1;
            oe_n_bit = 1'b0;
          end
        end
      end
      assign line_d[k] = line_bit;
      assign line_oe_n_d[k] = oe_n_bit;
    end
  endgenerate

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      line_q <= {LINES{1'b0}};
      line_oe_n_q <= {LINES{1'b1}};
    end else if (ce_i) begin
      line_q <= line_d;
      line_oe_n_q <= line_oe_n_d;
    end
  end

  // segment-common duty as a common count for the companion scanner
  assign segment_common_count_o = (size_q[2:1] == 2'h3) ? 4'h8 : {1'b0, size_q} + 4'h2;
  assign segment_common_scan_o = seg_scan_on;
  assign dot_matrix_scan_o = dot_scan_on;
  assign drive_line_o = line_q;
  assign drive_line_oe_n_o = line_oe_n_q;
  assign port0_display_sel_o = port0_en_q;
  assign port1_display_sel_o = port1_en_q;
  assign port2_display_sel_o = port2_en_q;
  assign port3_display_sel_o = port3_en_q;
  assign sfr_rdata_o = sfr_rdata_q;

endmodule // led_dot_matrix_scan_driver

//--- pkg/led_dmx_regs.vh
`ifndef LED_DOT_SCAN_REGS_VH
`define LED_DOT_SCAN_REGS_VH

// Register offsets on the special function register port
`define REG_PORT0_PIN_EN 8'h86
`define REG_PORT2_PIN_EN 8'h8E
`define REG_PORT1_PIN_EN 8'hAC
`define REG_DISP_CTRL 8'hB1
`define REG_DISP_CTRL2 8'hB2
`define REG_PORT3_PIN_EN 8'hB3

// Reset values
`define RST_PIN_EN 8'h00
`define RST_PORT2_PIN_EN 2'h0
`define RST_BRIGHTNESS 3'h7
`define RST_BRIGHT_MODE 1'b0
`define RST_SIZE 3'h0
`define RST_ENABLE 1'b0
`define RST_PRESCALER 2'h0
`define RST_LCD_LED 1'b0
`define RST_SCAN_MODE 2'h0

// Field positions in display_control
`define POS_DISPLAY_ENABLE 7
`define POS_SIZE_LO 4
`define POS_BRIGHT_MODE 3
`define POS_BRIGHT_LO 0
// Field positions in display_control_second
`define POS_PRESCALER_LO 5
`define POS_LCD_LED 4
`define POS_SCAN_MODE_LO 0

// Scan mode encodings
`define MODE_SEG_COMMON 2'h0
`define MODE_DOT_MATRIX 2'h2

// Display memory window
`define DMEM_BASE 16'hC800
`define DMEM_LAST 16'hC806

// Prescaler: divide by 64 shifted right by the field value
`define PSC_MAX_DIV 7'h40
// Index of the last LED clock tick in a scan slot; a slot lasts eight ticks
`define SLOT_TICKS 3'h7

`endif

//--- src/display_memory.v
module display_memory #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire wr_en_i,
  input wire [AW-1:0] wr_addr_i,
  input wire [WIDTH-1:0] wr_data_i,
  input wire rd_en_i,
  input wire [AW-1:0] rd_addr_i,
  output wire [WIDTH-1:0] rd_data_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [WIDTH-1:0] rd_data_q;

  always @(posedge core_clk_i) begin
    if (ce_i && wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // Read port is registered so the scanner sees data one cycle after the request
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      rd_data_q <= {WIDTH{1'b0}};
    end else if (ce_i && rd_en_i) begin
      rd_data_q <= mem[rd_addr_i];
    end
  end

  assign rd_data_o = rd_data_q;

endmodule // display_memory

//--- dv/led_dmx_assertions.sv
module led_dot_scan_checker (
  input wire core_clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [7:0] sfr_addr_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [7:0] sfr_wdata_i,
  input wire [7:0] sfr_rdata_o,
  input wire [7:0] drive_line_o,
  input wire [7:0] drive_line_oe_n_o,
  input wire [7:0] port0_display_sel_o,
  input wire [1:0] port2_display_sel_o,
  input wire [7:0] port3_display_sel_o,
  input wire dot_matrix_scan_o,
  input wire segment_common_scan_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire [7:0] pin_en = {port3_display_sel_o[4], port3_display_sel_o[7], port2_display_sel_o, port0_display_sel_o[3:0]};
  sequence s_ctl_wr;
    ce_i && sfr_wr_i && sfr_addr_i == 8'hB1;
  endsequence
  sequence s_ctl_rd;
    ce_i && sfr_rd_i && !sfr_wr_i && sfr_addr_i == 8'hB1;
  endsequence
  sequence s_scan_off;
    !dot_matrix_scan_o ##1 !dot_matrix_scan_o;
  endsequence
  chk_reset_release: assert property ($fell(rst_i) |-> drive_line_oe_n_o == 8'hFF && drive_line_o == 8'h00)
    else $error("lines driven right after reset");
  chk_one_common: assert property ($onehot0(~drive_line_oe_n_o & ~drive_line_o))
    else $error("more than one common line sinking");
  chk_released_low: assert property ((drive_line_o & drive_line_oe_n_o) == 8'h00)
    else $error("released line shows a high level");
  // Two quiet cycles of the mask first, since the outputs lag the state by one
  chk_pin_gating: assert property (pin_en == $past(pin_en) && pin_en == $past(pin_en, 2)
    |-> (~pin_en & ~drive_line_oe_n_o) == 8'h00)
    else $error("line driven without its pin enable");
  chk_scan_off_idle: assert property (s_scan_off |=> drive_line_oe_n_o == 8'hFF)
    else $error("line driven while scan is off");
  chk_start_fetch: assert property ($rose(dot_matrix_scan_o) |-> (drive_line_oe_n_o == 8'hFF) [*4])
    else $error("line driven during the first fetch");
  chk_mode_exclusive: assert property (!(dot_matrix_scan_o && segment_common_scan_o))
    else $error("both scan modes active");
  chk_ctl_readback: assert property (s_ctl_wr ##2 s_ctl_rd |=> sfr_rdata_o == $past(sfr_wdata_i, 3))
    else $error("control register read back differs");
  chk_sel_copy: assert property (ce_i && sfr_wr_i && sfr_addr_i == 8'h86
    |=> port0_display_sel_o == $past(sfr_wdata_i))
    else $error("port0 pin enable not copied");
endmodule // led_dot_scan_checker

bind led_dot_matrix_scan_driver led_dot_scan_checker i_chk (.core_clk_i, .rst_i, .ce_i, .sfr_addr_i, .sfr_wr_i,
  .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .drive_line_o, .drive_line_oe_n_o, .port0_display_sel_o,
  .port2_display_sel_o, .port3_display_sel_o, .dot_matrix_scan_o, .segment_common_scan_o);

//--- dv/led_matrix_array.sv
module led_matrix_array (
  input wire core_clk_i,
  input wire clear_i,
  input wire [7:0] drive_line_o,
  input wire [7:0] drive_line_oe_n_o,
  output logic [55:0] lit_o
);
  timeunit 1ns;
  timeprecision 100ps;
  always @(posedge core_clk_i) begin
    if (clear_i) begin
      lit_o <= '0;
    end else begin
      for (int c = 0; c < 8; c++) begin
        if (!drive_line_oe_n_o[c] && !drive_line_o[c]) begin
          for (int k = 0; k < 8; k++) begin
            if (k != c && !drive_line_oe_n_o[k] && drive_line_o[k]) begin
              lit_o[c * 7 + (k < c ? k : k - 1)] <= 1'b1;
            end
          end
        end
      end
    end
  end
endmodule // led_matrix_array

//--- dv/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_i = 0, rst_i = 1, ce_i = 1, sfr_wr_i = 0, sfr_rd_i = 0, dmem_wr_i = 0, leds_clear = 1;
  logic [7:0] sfr_addr_i = 0, sfr_wdata_i = 0, dmem_wdata_i = 0;
  logic [15:0] dmem_addr_i = 0;
  wire [7:0] sfr_rdata_o, drive_line_o, drive_line_oe_n_o;
  wire [7:0] port0_display_sel_o, port1_display_sel_o, port3_display_sel_o;
  wire [1:0] port2_display_sel_o;
  wire [3:0] segment_common_count_o;
  wire dot_matrix_scan_o, segment_common_scan_o;
  wire [55:0] lit;
  int errors = 0, checks = 0;
  logic [7:0] mem [7];
  int cols_t [6] = '{4, 5, 6, 7, 7, 8};
  int rows_t [6] = '{4, 5, 6, 6, 7, 7};
  int csz [5] = '{5, 0, 5, 4, 2}, cbm [5] = '{1, 0, 0, 1, 0}, clv [5] = '{7, 3, 0, 0, 5}, cps [5] = '{3, 2, 3, 1, 0};
  logic [7:0] cmk [5] = '{8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h00};
  logic [7:0] adr [7] = '{8'h86, 8'h8E, 8'hAC, 8'hB1, 8'hB2, 8'hB3, 8'h55};
  logic [7:0] rsv [7] = '{8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00};
  logic [7:0] msk [7] = '{8'hFF, 8'h03, 8'hFF, 8'hFF, 8'h73, 8'hFF, 8'h00};
  always #2.5 core_clk_i = ~core_clk_i;
  led_dot_matrix_scan_driver i_dut (.core_clk_i, .rst_i, .ce_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i,
    .sfr_rdata_o, .dmem_addr_i, .dmem_wr_i, .dmem_wdata_i, .drive_line_o, .drive_line_oe_n_o, .port0_display_sel_o,
    .port1_display_sel_o, .port2_display_sel_o, .port3_display_sel_o, .dot_matrix_scan_o, .segment_common_scan_o,
    .segment_common_count_o);
  led_matrix_array i_leds (.core_clk_i, .clear_i(leds_clear), .drive_line_o, .drive_line_oe_n_o, .lit_o(lit));
  task automatic ck(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (e !== s) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1;
    @(negedge core_clk_i);
    sfr_wr_i = 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk_i);
    sfr_addr_i = a;
    sfr_rd_i = 1;
    @(negedge core_clk_i);
    sfr_rd_i = 0;
    d = sfr_rdata_o;
  endtask
  task automatic xw(input int n, input logic [7:0] d);
    @(negedge core_clk_i);
    dmem_addr_i = 16'hC800 + 16'(n);
    dmem_wdata_i = d;
    dmem_wr_i = 1;
    @(negedge core_clk_i);
    dmem_wr_i = 0;
  endtask
  function automatic logic exp_lit(input int n, input int i, input logic [7:0] m);
    int c, j, k;
    c = n / 7;
    j = n % 7;
    k = j < c ? j : j + 1;
    return mem[n / 8][n % 8] && c < cols_t[csz[i]] && j < rows_t[csz[i]] && m[c] && m[k] && (cbm[i] == 1 || clv[i] > 0);
  endfunction
  task tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge core_clk_i);
    errors++;
    tally_and_finish;
  end
  initial begin
    logic [7:0] d, m;
    void'($urandom(21));
    cmk[4] = $urandom;
    repeat (16) @(negedge core_clk_i);
    rst_i = 0;
    foreach (adr[i]) begin
      rd(adr[i], d);
      ck("reset value", rsv[i], d);
      m = $urandom;
      wr(adr[i], m);
      rd(adr[i], d);
      ck("readback", m & msk[i], d);
    end
    wr(8'h86, 8'h5A);
    // A frozen clock enable must swallow the write completely
    ce_i = 0;
    wr(8'h86, 8'hA5);
    ce_i = 1;
    ck("frozen write", 8'h5A, port0_display_sel_o);
    for (int i = 0; i < 128; i++) begin
      wr(8'hB2, {3'b001, i[5], 2'b00, i[1:0]});
      wr(8'hB1, {i[6], i[4:2], 4'h7});
      ck("dot scan on", i[6] && i[5] && i[1:0] == 2 && i[4:2] < 6, dot_matrix_scan_o);
      ck("seg scan on", i[6] && i[5] && i[1:0] == 0, segment_common_scan_o);
      ck("commons", i[4:2] > 5 ? 8 : i[4:2] + 2, segment_common_count_o);
    end
    for (int i = 0; i < 5; i++) begin
      wr(8'hB1, 8'h00);
      repeat (3) @(negedge core_clk_i);
      ck("released", 8'hFF, drive_line_oe_n_o);
      for (int b = 0; b < 7; b++) begin
        mem[b] = $urandom;
        xw(b, mem[b]);
      end
      xw(7, 8'hFF);
      m = cmk[i];
      wr(8'h86, {4'h0, m[3:0]});
      wr(8'h8E, {6'h00, m[5:4]});
      wr(8'hB3, {m[6], 2'b00, m[7], 4'h0});
      wr(8'hAC, m);
      ck("port1 sel", m, port1_display_sel_o);
      ck("port2 sel", m[5:4], port2_display_sel_o);
      ck("port3 sel", {m[6], 2'b00, m[7], 4'h0}, port3_display_sel_o);
      wr(8'hB2, {1'b0, 2'(cps[i]), 5'h12});
      leds_clear = 0;
      wr(8'hB1, {1'b1, 3'(csz[i]), 1'(cbm[i]), 3'(clv[i])});
      // Two whole frames, so a frame begun mid-way is still seen complete
      repeat (16 * (4 + 8 * (64 >> cps[i])) + 40) @(negedge core_clk_i);
      for (int n = 0; n < 56; n++) ck("dot", exp_lit(n, i, m), lit[n]);
      leds_clear = 1;
    end
    tally_and_finish;
  end
endmodule // tb
